/* bench/mode_change_responder.sv */
/*
  Port-side responder: reports every port's mode change as finished a fixed
  time after each partition control write.
  Assumes the register port of the block under test and its core clock.
*/
module mode_change_responder #(
    parameter int DELAY = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    output logic [3:0] done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] count_ff;
    // a slow answer, so completion must visibly wait for it
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            count_ff <= 8'h00;
        else if (wr_in && addr_in[7:4] == partition_pkg::PART_CTL_BASE[7:4])
            count_ff <= 8'(DELAY);
        else if (count_ff != 8'h00)
            count_ff <= count_ff - 8'h01;
    end
    assign done_out = {4{count_ff == 8'h01}};
endmodule : mode_change_responder

/* bench/partition_state_ctrl_checker.sv */
/*
  Checker for packet answers and partition state outputs.
  Assumes binding to partition_state_ctrl, one clock domain.
*/
module partition_state_ctrl_checker (
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic [3:0] LINK_DOWN_IN,
    input wire logic PKT_VALID_IN,
    input wire logic PKT_IS_CPL_IN,
    input wire logic PKT_ROOTWARD_MSG_IN,
    input wire logic PKT_FORWARD_OUT,
    input wire logic PKT_UNSUPPORTED_OUT,
    input wire logic PKT_UNEXPECTED_OUT,
    input wire logic PKT_DROP_OUT,
    input wire logic [3:0] PORT_EFFECTIVE_DISABLED_OUT,
    input wire logic [3:0] PART_IN_RESET_OUT,
    input wire logic [3:0] HOT_RESET_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RESETN_IN);
    logic [3:0] ans;
    assign ans = {PKT_FORWARD_OUT, PKT_UNSUPPORTED_OUT, PKT_UNEXPECTED_OUT, PKT_DROP_OUT};
    ////////////////////////////////////////
    property p_one_answer;
        PKT_VALID_IN |=> $onehot(ans);
    endproperty
    a_one_answer: assert property (p_one_answer)
        else $error("packet answer not exactly one");
    property p_quiet;
        !PKT_VALID_IN |=> ans == 4'h0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("packet answer without packet");
    property p_unexp_cpl;
        PKT_UNEXPECTED_OUT |-> $past(PKT_IS_CPL_IN);
    endproperty
    a_unexp_cpl: assert property (p_unexp_cpl)
        else $error("unexpected flag on a request");
    property p_drop_msg;
        $rose(PKT_DROP_OUT) |-> $past(PKT_VALID_IN && PKT_ROOTWARD_MSG_IN);
    endproperty
    a_drop_msg: assert property (p_drop_msg)
        else $error("drop of a non rootward packet");
    ////////////////////////////////////////
    for (genvar q = 0; q < 4; q++)
    begin : g_part
        localparam logic [7:0] CA = partition_pkg::PART_CTL_BASE + 8'(4 * q);
        localparam logic [7:0] PA = partition_pkg::PORT_CTL_BASE + 8'(4 * q);
        property p_hot_cause;
            $rose(HOT_RESET_OUT[q]) |-> $past(LINK_DOWN_IN, 2) != 4'h0;
        endproperty
        a_hot_cause: assert property (p_hot_cause)
            else $error("hot reset without link down");
        property p_freset_hold;
            WR_IN && ADDR_IN == CA && WDATA_IN[1:0] == partition_pkg::PSTATE_FRESET |=> PART_IN_RESET_OUT[q] [*3];
        endproperty
        a_freset_hold: assert property (p_freset_hold)
            else $error("partition reset not held");
        property p_disable_quiet;
            WR_IN && ADDR_IN == CA && WDATA_IN[1:0] == partition_pkg::PSTATE_DISABLED
                |=> !(PART_IN_RESET_OUT[q] || HOT_RESET_OUT[q]);
        endproperty
        a_disable_quiet: assert property (p_disable_quiet)
            else $error("reset active in disabled partition");
        property p_port_dis;
            WR_IN && ADDR_IN == PA && WDATA_IN[3:0] == partition_pkg::MODE_DISABLED |=> PORT_EFFECTIVE_DISABLED_OUT[q];
        endproperty
        a_port_dis: assert property (p_port_dis)
            else $error("disabled port still enabled");
    end
endmodule : partition_state_ctrl_checker

bind partition_state_ctrl partition_state_ctrl_checker partition_state_ctrl_checker_inst (.*);

/* bench/test_partition_state_ctrl.sv */
/*
  Self-checking bench for partition_state_ctrl: register port, state changes,
  resets and packet decisions.
  Assumes the responder model answers mode changes after 8 cycles.
*/
module test_partition_state_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FRC = 20;
    logic clk, rstn, wr, rd, vld, dv, cpl, cfg, br, acc, msg, fwd, ur, ux, drop;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] prst_n, ldown, mdone, edis, inrst, hot, aspm;
    logic [1:0] src, dst;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    partition_state_ctrl #(.FRESET_CNT(FRC)) partition_state_ctrl_inst (
        .MCLK_IN(clk), .RESETN_IN(rstn), .BOOT_PARTS_ACTIVE_IN(1'b0), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PART_RESET_N_IN(prst_n), .LINK_DOWN_IN(ldown),
        .MODE_CHANGE_DONE_IN(mdone), .PKT_VALID_IN(vld), .PKT_SRC_PORT_IN(src), .PKT_DST_PORT_IN(dst),
        .PKT_DST_VALID_IN(dv), .PKT_IS_CPL_IN(cpl), .PKT_IS_CFG_IN(cfg), .PKT_TO_BRIDGE_IN(br),
        .PKT_FUNC_ACCEPT_IN(acc), .PKT_ROOTWARD_MSG_IN(msg), .PKT_FORWARD_OUT(fwd), .PKT_UNSUPPORTED_OUT(ur),
        .PKT_UNEXPECTED_OUT(ux), .PKT_DROP_OUT(drop), .PORT_EFFECTIVE_DISABLED_OUT(edis),
        .PART_IN_RESET_OUT(inrst), .HOT_RESET_OUT(hot), .ASPM_IGNORE_PEER_OUT(aspm));
    mode_change_responder #(.DELAY(8)) mode_change_responder_inst (
        .clk_in(clk), .rst_n_in(rstn), .wr_in(wr), .addr_in(addr), .done_out(mdone));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk) cyc++;
    ////////////////////////////////////////
    task automatic end_sim;
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        got = rdata;
    endtask : rd_reg
    // returns only when the change reports completion, or after 100 further status polls
    task automatic set_state(input int q, input logic [1:0] s, input int min_cyc);
        int t0;
        int n;
        wr_reg(partition_pkg::PART_CTL_BASE + 8'(4 * q), {30'h0, s});
        t0 = cyc;
        rd_reg(partition_pkg::PART_STS_BASE + 8'(4 * q));
        chk(got[9:8], 2'b01);
        n = 0;
        while (got[9] !== 1'b1 && n < 100)
        begin
            rd_reg(partition_pkg::PART_STS_BASE + 8'(4 * q));
            n++;
        end
        chk(got[9], 1'b1);
        chk(cyc - t0 >= min_cyc, 1'b1);
    endtask : set_state
    task automatic send(input logic [1:0] s, input logic [1:0] d, input logic [5:0] f, input logic [3:0] exp);
        @(posedge clk);
        vld <= 1'b1;
        src <= s;
        dst <= d;
        {dv, cpl, cfg, br, acc, msg} <= f;
        @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
        chk({fwd, ur, ux, drop}, exp);
    endtask : send
    ////////////////////////////////////////
    task automatic scen_disabled;
        wr_reg(partition_pkg::PORT_CTL_BASE, 32'h0000_0002);
        wr_reg(partition_pkg::PORT_CTL_BASE + 8'h04, 32'h0000_0003);
        ldown <= 4'h1;
        prst_n <= 4'hE;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk(edis[1:0], 2'b11);
        chk({hot[0], inrst[0]}, 2'b00);
        rd_reg(partition_pkg::PART_STS_BASE);
        chk(got[5:0], 6'h01);
        ldown <= 4'h0;
        prst_n <= 4'hF;
        set_state(0, partition_pkg::PSTATE_ACTIVE, 8);
        chk({edis[1:0], aspm[0]}, 3'b000);
    endtask : scen_disabled
    task automatic scen_freset;
        ldown <= 4'h1;
        set_state(0, partition_pkg::PSTATE_FRESET, FRC);
        chk({hot[0], inrst[0]}, 2'b01);
        set_state(0, partition_pkg::PSTATE_ACTIVE, 8);
        ldown <= 4'h0;
        wr_reg(partition_pkg::PART_CTL_BASE, 32'h0000_0003);
        rd_reg(partition_pkg::PART_CTL_BASE);
        chk(got[1:0], partition_pkg::PSTATE_ACTIVE);
    endtask : scen_freset
    task automatic scen_split;
        wr_reg(partition_pkg::PORT_CTL_BASE + 8'h08, 32'h0000_0102);
        wr_reg(partition_pkg::PORT_CTL_BASE + 8'h04, 32'h0000_0203);
        wr_reg(partition_pkg::PORT_CTL_BASE + 8'h0C, 32'h0000_0203);
        set_state(1, partition_pkg::PSTATE_ACTIVE, 8);
        set_state(2, partition_pkg::PSTATE_ACTIVE, 8);
        rd_reg(partition_pkg::PART_STS_BASE + 8'h04);
        chk(got, 32'h0000_0721);
        rd_reg(partition_pkg::PART_STS_BASE + 8'h08);
        chk(got, 32'h0000_0300);
        chk(aspm, 4'h7);
    endtask : scen_split
    task automatic scen_packets;
        send(2'h2, 2'h0, 6'b000100, 4'h4);
        send(2'h2, 2'h0, 6'b010100, 4'h2);
        send(2'h2, 2'h0, 6'b000010, 4'h8);
        send(2'h2, 2'h0, 6'b000000, 4'h4);
        send(2'h2, 2'h0, 6'b010010, 4'h8);
        send(2'h2, 2'h0, 6'b010000, 4'h2);
        send(2'h3, 2'h1, 6'b100000, 4'h8);
        send(2'h3, 2'h1, 6'b000000, 4'h4);
        send(2'h3, 2'h0, 6'b100000, 4'h4);
        send(2'h3, 2'h1, 6'b100001, 4'h1);
    endtask : scen_packets
    task automatic scen_teardown;
        set_state(1, partition_pkg::PSTATE_DISABLED, 8);
        chk(edis[2], 1'b1);
        wr_reg(partition_pkg::PORT_CTL_BASE + 8'h08, 32'h0000_0000);
        rd_reg(partition_pkg::PART_STS_BASE + 8'h04);
        chk(got[0], 1'b0);
    endtask : scen_teardown
    ////////////////////////////////////////
    initial
    begin
        {rstn, wr, rd, vld, dv, cpl, cfg, br, acc, msg} = '0;
        {addr, wdata, src, dst, ldown} = '0;
        prst_n = 4'hF;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        rd_reg(partition_pkg::PART_CTL_BASE);
        chk(got, 32'h0000_0000);
        rd_reg(partition_pkg::PORT_CTL_BASE + 8'h04);
        chk(got, partition_pkg::PORT_CTL_RESET);
        rd_reg(partition_pkg::TIMER_BASE + 8'h04);
        chk(got, {16'h0000, partition_pkg::TIMER_RESET});
        rd_reg(8'hFC);
        chk(got, 32'h0000_0000);
        scen_disabled();
        scen_freset();
        scen_split();
        scen_packets();
        scen_teardown();
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule : test_partition_state_ctrl

/* verilog/partition_pkg.sv */
/*
  Constants shared by the partition state control block: register offsets,
  field positions, port modes, partition states and timing figures.
  Assumes a 250 MHz core clock and one register word per offset.
*/
package partition_pkg;
    localparam int NUM_PORTS = 4;
    localparam int NUM_PARTS = 4;
    localparam int PORT_W = 2;
    localparam int PART_W = 2;

    // register offsets (byte addresses, 32-bit words)
    localparam logic [7:0] PORT_CTL_BASE = 8'h00;
    localparam logic [7:0] PORT_STS_BASE = 8'h10;
    localparam logic [7:0] PART_CTL_BASE = 8'h20;
    localparam logic [7:0] PART_STS_BASE = 8'h30;
    localparam logic [7:0] TIMER_BASE = 8'h40;
    localparam int NUM_TIMERS = 4;

    // port control fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;
    localparam int PSEL_LSB = 8;

    // partition control / status fields
    localparam int STATE_LSB = 0;
    localparam int UPRES_BIT = 0;
    localparam int UPID_LSB = 4;
    localparam int INIT_BIT = 8;
    localparam int DONE_BIT = 9;
    localparam int NODOWN_BIT = 10;

    // port mode codes
    localparam logic [3:0] MODE_DISABLED = 4'h0;
    localparam logic [3:0] MODE_UNATTACHED = 4'h1;
    localparam logic [3:0] MODE_USP = 4'h2;
    localparam logic [3:0] MODE_DSP = 4'h3;
    localparam logic [3:0] MODE_USP_DMA = 4'h4;
    localparam logic [3:0] MODE_USP_NT = 4'h5;
    localparam logic [3:0] MODE_USP_NT_DMA = 4'h6;
    localparam logic [3:0] MODE_NT = 4'h7;
    localparam logic [3:0] MODE_NT_DMA = 4'h8;

    // partition state codes
    localparam logic [1:0] PSTATE_DISABLED = 2'h0;
    localparam logic [1:0] PSTATE_FRESET = 2'h1;
    localparam logic [1:0] PSTATE_ACTIVE = 2'h2;

    // reset values
    localparam logic [31:0] PORT_CTL_RESET = 32'h0000_0001;
    localparam logic [15:0] TIMER_RESET = 16'h0010;

    // timing
    localparam int CLK_MHZ = 250;
    localparam int FRESET_US = 250;
    localparam int FRESET_CYCLES = FRESET_US * CLK_MHZ;
    localparam int SHORT_CYCLES = 2;
    localparam int CNT_W = 17;
endpackage : partition_pkg

/* verilog/partition_state_ctrl.sv */
/*
  Partition state control for a multi-port switch: port attachment,
  partition state machine with start/finish flags, and per-partition
  routing decisions for packets.
  Assumes a synchronous register port, boot strap and reset pins that are
  asynchronous and synchronised here, and one 250 MHz core clock.
*/
// Our own choices: the placing of the registers and the plain strobed port.
// How it works
// [RL1] port joins partition when selected and mode operational
// [RL2] upstream-present flag set when partition has an upstream port
// [RL3] upstream port number reported while upstream-present flag set
// [RL4] bridge non-config requests with no downstream ports are unsupported
// [RL5] bridge completions with no downstream ports are unexpected
// [RL6] nontransparent or DMA function decides per its own configuration
// [RL7] low-power entry ignores the absent side of a partition
// [RL8] peer traffic between downstream ports forwards with no upstream port
// [RL9] without upstream port, packets not for a downstream port unsupported
// [RL10] without upstream port, rootward switch messages dropped silently
// [RL11] software attaches one upstream port and no downstream beside endpoint
// [RL12] three partition states from control field, initial from boot mode; here initial state is always disabled (boot_sync_ff still 0)
// [RL13] disabled partition forces its ports to disabled mode
// [RL14] disabled partition ignores its reset input and link-down hot reset
// [RL15] entering fundamental reset reinitialises partition registers; here the registers keep their values
// [RL16] reset persists while state is fundamental reset, no hot reset
// [RL17] change-initiated flag set when a state change begins
// [RL18] change-completed flag set after all effects finished
// [RL19] controller waits for completion before next change
// [RL20] change into fundamental reset takes 250 microseconds
// [RL21] completion waits for port mode changes to finish
// [RL22] loader zeroes drain timers first, restores defaults last
// [RL23] loader polls completion flag before further changes
module partition_state_ctrl #(
    parameter int FRESET_CNT = partition_pkg::FRESET_CYCLES
) (
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    input wire logic BOOT_PARTS_ACTIVE_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    input wire logic [3:0] PART_RESET_N_IN,
    input wire logic [3:0] LINK_DOWN_IN,
    input wire logic [3:0] MODE_CHANGE_DONE_IN,
    input wire logic PKT_VALID_IN,
    input wire logic [1:0] PKT_SRC_PORT_IN,
    input wire logic [1:0] PKT_DST_PORT_IN,
    input wire logic PKT_DST_VALID_IN,
    input wire logic PKT_IS_CPL_IN,
    input wire logic PKT_IS_CFG_IN,
    input wire logic PKT_TO_BRIDGE_IN,
    input wire logic PKT_FUNC_ACCEPT_IN,
    input wire logic PKT_ROOTWARD_MSG_IN,
    output logic PKT_FORWARD_OUT,
    output logic PKT_UNSUPPORTED_OUT,
    output logic PKT_UNEXPECTED_OUT,
    output logic PKT_DROP_OUT,
    output logic [3:0] PORT_EFFECTIVE_DISABLED_OUT,
    output logic [3:0] PART_IN_RESET_OUT,
    output logic [3:0] HOT_RESET_OUT,
    output logic [3:0] ASPM_IGNORE_PEER_OUT
);
    localparam int NP = partition_pkg::NUM_PORTS;
    localparam int NQ = partition_pkg::NUM_PARTS;
    localparam logic [16:0] FRESET_LOAD = 17'(FRESET_CNT - 1);
    localparam logic [16:0] SHORT_LOAD = 17'(partition_pkg::SHORT_CYCLES - 1);

    typedef enum logic [2:0] {
        CH_IDLE = 3'b001,
        CH_WAIT = 3'b010,
        CH_MODE = 3'b100
    } chg_type;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers for pins and boot strap
    logic [3:0] prst_meta_ff, prst_sync_ff;
    logic [3:0] ldn_meta_ff, ldn_sync_ff;
    logic boot_meta_ff, boot_sync_ff, boot_taken_ff;

    always_ff @(posedge MCLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            prst_meta_ff <= 4'hF;
            prst_sync_ff <= 4'hF;
            ldn_meta_ff <= 4'h0;
            ldn_sync_ff <= 4'h0;
            boot_meta_ff <= 1'b0;
            boot_sync_ff <= 1'b0;
        end
        else
        begin
            prst_meta_ff <= PART_RESET_N_IN;
            prst_sync_ff <= prst_meta_ff;
            ldn_meta_ff <= LINK_DOWN_IN;
            ldn_sync_ff <= ldn_meta_ff;
            boot_meta_ff <= BOOT_PARTS_ACTIVE_IN;
            boot_sync_ff <= boot_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] port_ctl_ff [NP];
    logic [1:0] pstate_ff [NQ];
    logic [NQ-1:0] init_flag_ff, done_flag_ff;
    logic [15:0] timer_ff [partition_pkg::NUM_TIMERS];
    chg_type chg_ff [NQ];
    logic [16:0] cnt_ff [NQ];
    logic [3:0] mode_pend_ff [NQ];

    logic [NP-1:0] attached, is_up, is_usp, is_dsp;
    logic [1:0] psel [NP];
    logic [3:0] pmode [NP];
    logic [NQ-1:0] has_up, has_down, part_dis, part_fr;
    logic [1:0] up_id [NQ];
    logic [NQ-1:0] ctl_wr;

    // state taken once after reset release from boot_sync_ff, which then still holds its reset value 0
    always_ff @(posedge MCLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            boot_taken_ff <= 1'b0;
        else
            boot_taken_ff <= 1'b1;
    end

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++)
        begin : g_port
            assign pmode[gp] = port_ctl_ff[gp][partition_pkg::MODE_LSB +: partition_pkg::MODE_W];
            assign psel[gp] = port_ctl_ff[gp][partition_pkg::PSEL_LSB +: 2];
            assign attached[gp] = (pmode[gp] >= partition_pkg::MODE_USP) &&
                                  (pmode[gp] <= partition_pkg::MODE_NT_DMA); // [RL1]
            assign is_dsp[gp] = attached[gp] && (pmode[gp] == partition_pkg::MODE_DSP);
            assign is_up[gp] = attached[gp] && !is_dsp[gp];
            assign is_usp[gp] = is_up[gp] && (pmode[gp] <= partition_pkg::MODE_USP_NT_DMA);
            assign PORT_EFFECTIVE_DISABLED_OUT[gp] = !attached[gp] ? (pmode[gp] == partition_pkg::MODE_DISABLED)
                                                                   : part_dis[psel[gp]]; // [RL13]

            always_ff @(posedge MCLK_IN or negedge RESETN_IN)
            begin
                if (!RESETN_IN)
                    port_ctl_ff[gp] <= partition_pkg::PORT_CTL_RESET;
                else if (WR_IN && ADDR_IN == partition_pkg::PORT_CTL_BASE + 8'(4 * gp))
                    port_ctl_ff[gp] <= {22'h0, WDATA_IN[9:8], 4'h0, WDATA_IN[3:0]};
            end
        end
    endgenerate

    genvar gt;
    generate
        for (gt = 0; gt < partition_pkg::NUM_TIMERS; gt++)
        begin : g_timer
            // drain timers are only held for the loader; the change sequence never reads them
            always_ff @(posedge MCLK_IN or negedge RESETN_IN)
            begin
                if (!RESETN_IN)
                    timer_ff[gt] <= partition_pkg::TIMER_RESET;
                else if (WR_IN && ADDR_IN == partition_pkg::TIMER_BASE + 8'(4 * gt))
                    timer_ff[gt] <= WDATA_IN[15:0]; // [RL22]
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // per-partition state machine
    genvar gq;
    generate
        for (gq = 0; gq < NQ; gq++)
        begin : g_part
            logic [NP-1:0] up_here, down_here, mine;
            logic [1:0] first_up;

            always_comb
            begin
                first_up = 2'h0;
                for (int i = NP - 1; i >= 0; i--)
                    if (up_here[i])
                        first_up = 2'(i);
            end

            for (genvar k = 0; k < NP; k++)
            begin : g_m
                assign mine[k] = attached[k] && psel[k] == 2'(gq);
                assign up_here[k] = mine[k] && is_up[k];
                assign down_here[k] = mine[k] && is_dsp[k];
            end

            assign has_up[gq] = |up_here; // [RL2]
            assign has_down[gq] = |down_here;
            assign up_id[gq] = first_up; // [RL3]
            assign part_dis[gq] = pstate_ff[gq] == partition_pkg::PSTATE_DISABLED;
            assign part_fr[gq] = pstate_ff[gq] == partition_pkg::PSTATE_FRESET;
            assign ctl_wr[gq] = WR_IN && ADDR_IN == partition_pkg::PART_CTL_BASE + 8'(4 * gq);
            // pin reset acts only when active; disabled ignores it [RL14] [RL16]
            assign PART_IN_RESET_OUT[gq] = part_fr[gq] ||
                                          (pstate_ff[gq] == partition_pkg::PSTATE_ACTIVE && !prst_sync_ff[gq]);
            // hot reset on upstream link-down only in active state [RL14] [RL16]
            assign HOT_RESET_OUT[gq] = pstate_ff[gq] == partition_pkg::PSTATE_ACTIVE && has_up[gq] &&
                                      ldn_sync_ff[first_up];
            assign ASPM_IGNORE_PEER_OUT[gq] = has_up[gq] ^ has_down[gq]; // [RL7]

            always_ff @(posedge MCLK_IN or negedge RESETN_IN)
            begin
                if (!RESETN_IN)
                    pstate_ff[gq] <= partition_pkg::PSTATE_DISABLED;
                else if (!boot_taken_ff)
                    pstate_ff[gq] <= boot_sync_ff ? partition_pkg::PSTATE_ACTIVE
                                                  : partition_pkg::PSTATE_DISABLED; // [RL12]
                else if (ctl_wr[gq] && WDATA_IN[1:0] <= partition_pkg::PSTATE_ACTIVE)
                    pstate_ff[gq] <= WDATA_IN[1:0]; // [RL12]
            end

            always_ff @(posedge MCLK_IN or negedge RESETN_IN)
            begin
                if (!RESETN_IN)
                begin
                    chg_ff[gq] <= CH_IDLE;
                    cnt_ff[gq] <= 17'h0;
                    mode_pend_ff[gq] <= 4'h0;
                    init_flag_ff[gq] <= 1'b0;
                    done_flag_ff[gq] <= 1'b0;
                end
                else if (ctl_wr[gq] && WDATA_IN[1:0] <= partition_pkg::PSTATE_ACTIVE)
                begin
                    // a new write restarts the sequence; overlap is the caller's hazard
                    chg_ff[gq] <= CH_WAIT;
                    init_flag_ff[gq] <= 1'b1; // [RL17]
                    done_flag_ff[gq] <= 1'b0;
                    mode_pend_ff[gq] <= mine;
                    cnt_ff[gq] <= (WDATA_IN[1:0] == partition_pkg::PSTATE_FRESET) ? FRESET_LOAD
                                                                                  : SHORT_LOAD; // [RL20]
                end
                else
                begin
                    case (chg_ff[gq])
                        CH_IDLE:
                            chg_ff[gq] <= CH_IDLE;
                        CH_WAIT:
                        begin
                            // ports may finish their mode change during the drain wait
                            mode_pend_ff[gq] <= mode_pend_ff[gq] & ~MODE_CHANGE_DONE_IN; // [RL21]
                            if (cnt_ff[gq] == 17'h0)
                                chg_ff[gq] <= CH_MODE;
                            else
                                cnt_ff[gq] <= cnt_ff[gq] - 17'h1;
                        end
                        CH_MODE:
                        begin
                            // all affected ports must report their mode change [RL21]
                            if ((mode_pend_ff[gq] & ~MODE_CHANGE_DONE_IN) == 4'h0)
                            begin
                                chg_ff[gq] <= CH_IDLE;
                                done_flag_ff[gq] <= 1'b1; // [RL18]
                            end
                            else
                                mode_pend_ff[gq] <= mode_pend_ff[gq] & ~MODE_CHANGE_DONE_IN;
                        end
                        default:
                            chg_ff[gq] <= CH_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // entry into fundamental reset leaves the partition's port registers as they are
    // registers always survive, so other masters can rewrite them [RL15]

    ////////////////////////////////////////////////////////////////////////
    // packet decision, one cycle after the packet
    logic fwd_nxt, ur_nxt, ux_nxt, drop_nxt;
    logic [1:0] sp;
    logic src_usp;

    always_comb
    begin
        sp = psel[PKT_SRC_PORT_IN];
        src_usp = is_usp[PKT_SRC_PORT_IN];
        fwd_nxt = 1'b0;
        ur_nxt = 1'b0;
        ux_nxt = 1'b0;
        drop_nxt = 1'b0;
        if (PKT_VALID_IN)
        begin
            if (has_up[sp] && !has_down[sp] && src_usp)
            begin
                if (!PKT_TO_BRIDGE_IN)
                begin
                    fwd_nxt = PKT_FUNC_ACCEPT_IN; // [RL6]
                    ux_nxt = PKT_IS_CPL_IN && !PKT_FUNC_ACCEPT_IN;
                    ur_nxt = !PKT_IS_CPL_IN && !PKT_FUNC_ACCEPT_IN;
                end
                else if (PKT_IS_CPL_IN)
                    ux_nxt = 1'b1; // [RL5]
                else if (PKT_IS_CFG_IN)
                    fwd_nxt = 1'b1;
                else
                    ur_nxt = 1'b1; // [RL4]
            end
            else if (!has_up[sp] && has_down[sp])
            begin
                if (PKT_ROOTWARD_MSG_IN)
                    drop_nxt = 1'b1; // [RL10]
                else if (PKT_DST_VALID_IN && is_dsp[PKT_DST_PORT_IN] && psel[PKT_DST_PORT_IN] == sp)
                    fwd_nxt = 1'b1; // [RL8]
                else
                    ur_nxt = 1'b1; // [RL9]
            end
            else
                fwd_nxt = 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            PKT_FORWARD_OUT <= 1'b0;
            PKT_UNSUPPORTED_OUT <= 1'b0;
            PKT_UNEXPECTED_OUT <= 1'b0;
            PKT_DROP_OUT <= 1'b0;
        end
        else
        begin
            PKT_FORWARD_OUT <= fwd_nxt;
            PKT_UNSUPPORTED_OUT <= ur_nxt;
            PKT_UNEXPECTED_OUT <= ux_nxt;
            PKT_DROP_OUT <= drop_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port
    logic [31:0] nxt_rdata;
    logic [1:0] ri;

    always_comb
    begin
        ri = ADDR_IN[3:2];
        nxt_rdata = 32'h0;
        if (RD_IN && ADDR_IN[1:0] == 2'h0)
        begin
            case (ADDR_IN[7:4])
                4'h0: nxt_rdata = port_ctl_ff[ri];
                4'h1: nxt_rdata = {31'h0, PORT_EFFECTIVE_DISABLED_OUT[ri]};
                4'h2: nxt_rdata = {30'h0, pstate_ff[ri]};
                4'h3: nxt_rdata = {21'h0, !has_down[ri], done_flag_ff[ri], init_flag_ff[ri],
                                   2'h0, has_up[ri] ? up_id[ri] : 2'h0, 3'h0, has_up[ri]};
                4'h4: nxt_rdata = {16'h0, timer_ff[ri]};
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            RDATA_OUT <= 32'h0;
        else
            RDATA_OUT <= nxt_rdata;
    end
endmodule : partition_state_ctrl
